// [src/imr_pkg.sv]
package imr_pkg;
	// register byte offsets on the avalon slave (word aligned)
	localparam logic [3:0] OFF_BUF    = 4'h0;
	localparam logic [3:0] OFF_CTRL   = 4'h4;
	localparam logic [3:0] OFF_STATUS = 4'h8;
	localparam logic [3:0] OFF_MASK   = 4'hC;
	// control register fields
	localparam int CTRL_RCV_BIT = 0;
	localparam int CTRL_ACK_BIT = 1;
	localparam int CTRL_ACKDT_BIT = 2;
	// status register fields (sticky; irq, ovf and collision write one to clear, full clears on a buffer read)
	localparam int ST_IRQ_BIT  = 0;
	localparam int ST_OVF_BIT  = 1;
	localparam int ST_WRITE_COLLISION_FLAG_BIT = 2;
	localparam int ST_FULL_BIT = 3;
	localparam logic [2:0] MASK_RESET = 3'h0;
	localparam logic [15:0] BRG_RELOAD_RESET = 16'h0031;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

	typedef enum logic [1:0] {
		IMR_IDLE = 2'b00,
		IMR_RECV = 2'b01,
		IMR_ACK  = 2'b10
	} imr_state_e;

	typedef struct packed {
		logic scl_oe;
		logic sda_oe;
	} imr_pins_s;
endpackage

// [src/imr_master_rx.sv]
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// How it works
// - setting receive_arm_bit in serial_control_two starts one byte reception
// - arming is ignored unless the engine is idle; the testbench re-arms mid-byte to check this
// - each baud rollover toggles scl; sda bits shift into serial_shift_reg
// - eighth falling edge clears arm, loads buffer, sets full and irq flags
// - after eight bits baud counting stops, scl held low, engine idles
// - reading serial_buffer clears buffer_full_flag
// - ack_sequence_enable after a byte drives one acknowledge bit on sda
// - byte completing while buffer_full_flag set and serial_buffer not read that cycle raises receive_overflow_flag
// - buffer write during reception is dropped and sets write_collision_flag
module imr_master_rx
	import imr_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               reset_n,
	input  wire logic [3:0]         avs_address,
	input  wire logic               avs_read,
	input  wire logic               avs_write,
	input  wire logic [31:0]        avs_writedata,
	output logic      [31:0]        avs_readdata,
	output logic                    avs_waitrequest,
	input  wire logic               scl_in,
	input  wire logic               sda_in,
	output imr_pkg::imr_pins_s      pins,
	output logic                    scl_out,
	output logic                    sda_out,
	output logic                    irq
);
	import imr_pkg::*;

	logic rst_m_q, rst_n_q;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rst_m_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_n_q <= rst_m_q;
		end
	end

	// pin synchronisers; only the second sda stage is read, scl_s_q is never used
	logic sda_m_q, sda_s_q, scl_m_q, scl_s_q;
	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
		end else begin
			sda_m_q <= sda_in;
			sda_s_q <= sda_m_q;
			scl_m_q <= scl_in;
			scl_s_q <= scl_m_q;
		end
	end

	imr_state_e state_q, state_d;
	logic [15:0] brg_q, brg_d, reload_q, reload_d;
	logic [3:0]  cnt_q, cnt_d;
	logic [7:0]  shift_q, shift_d, buf_q, buf_d;
	logic        scl_q, scl_d, sda_q, sda_d;
	logic        arm_q, arm_d, ackdt_q, ackdt_d;
	logic        full_q, full_d, irqf_q, irqf_d, ovf_q, ovf_d, write_collision_flag_q, write_collision_flag_d;
	logic [2:0]  mask_q, mask_d;
	logic        rd_ack_q, rd_ack_d;
	logic [31:0] rdata_q, rdata_d;

	logic wr_ctrl, wr_buf, wr_stat, wr_mask, rd_buf, rollover, byte_done;
	// writes take one cycle; reads answer after one wait cycle
	assign avs_waitrequest = avs_read && !rd_ack_q;
	assign wr_ctrl = avs_write && avs_address == OFF_CTRL;
	assign wr_buf  = avs_write && avs_address == OFF_BUF;
	assign wr_stat = avs_write && avs_address == OFF_STATUS;
	assign wr_mask = avs_write && avs_address == OFF_MASK;
	assign rd_buf  = avs_read && rd_ack_q && avs_address == OFF_BUF;
	assign rollover = brg_q == 16'h0000;
	// eighth falling edge: scl high and about to drop on the last bit
	assign byte_done = state_q == IMR_RECV && rollover && scl_q &&
		cnt_q == BITS_PER_BYTE;

	always_comb begin
		state_d = state_q;
		brg_d   = brg_q;
		reload_d = reload_q;
		cnt_d   = cnt_q;
		shift_d = shift_q;
		buf_d   = buf_q;
		scl_d   = scl_q;
		sda_d   = sda_q;
		arm_d   = arm_q;
		ackdt_d = ackdt_q;
		mask_d  = mask_q;
		full_d  = full_q;
		irqf_d  = irqf_q;
		ovf_d   = ovf_q;
		write_collision_flag_d  = write_collision_flag_q;
		if (wr_ctrl) begin
			reload_d = avs_writedata[31:16];
			ackdt_d  = avs_writedata[CTRL_ACKDT_BIT];
		end
		if (wr_mask)
			mask_d = avs_writedata[2:0];
		// write-one-to-clear first so a same-cycle hardware set wins
		if (wr_stat) begin
			if (avs_writedata[ST_IRQ_BIT])  irqf_d = 1'b0;
			if (avs_writedata[ST_OVF_BIT])  ovf_d = 1'b0;
			if (avs_writedata[ST_WRITE_COLLISION_FLAG_BIT]) write_collision_flag_d = 1'b0;
		end
		if (rd_buf)
			full_d = 1'b0;
		if (wr_buf) begin
			if (state_q == IMR_RECV)
				write_collision_flag_d = 1'b1;
			else
				buf_d = avs_writedata[7:0];
		end
		unique case (state_q)
		IMR_IDLE: begin
			scl_d = 1'b0;
			if (wr_ctrl && avs_writedata[CTRL_RCV_BIT]) begin
				state_d = IMR_RECV;
				arm_d = 1'b1;
				sda_d = 1'b1;
				cnt_d = 4'h0;
				brg_d = reload_q;
			end else if (wr_ctrl && avs_writedata[CTRL_ACK_BIT]) begin
				state_d = IMR_ACK;
				sda_d = ackdt_q;
				cnt_d = 4'h0;
				brg_d = reload_q;
			end
		end
		IMR_RECV: begin
			if (rollover) begin
				brg_d = reload_q;
				scl_d = !scl_q;
				if (!scl_q) begin
					// rising edge: sample msb first as scl goes high, before the high phase
					shift_d = {shift_q[6:0], sda_s_q};
					cnt_d = cnt_q + 4'h1;
				end
				if (byte_done) begin
					state_d = IMR_IDLE;
					arm_d  = 1'b0;
					buf_d  = shift_q;
					full_d = 1'b1;
					irqf_d = 1'b1;
					if (full_q && !rd_buf)
						ovf_d = 1'b1;
				end
			end else
				brg_d = brg_q - 16'h0001;
		end
		IMR_ACK: begin
			if (rollover) begin
				brg_d = reload_q;
				scl_d = !scl_q;
				if (scl_q) begin
					state_d = IMR_IDLE;
					sda_d = 1'b1;
					irqf_d = 1'b1;
				end
			end else
				brg_d = brg_q - 16'h0001;
		end
		default: state_d = IMR_IDLE;
		endcase
	end

	always_comb begin
		rd_ack_d = avs_read && !rd_ack_q;
		rdata_d = UNMAPPED_READ;
		unique case (avs_address)
		OFF_BUF:    rdata_d = {24'h000000, buf_q};
		OFF_CTRL:   rdata_d = {reload_q, 13'h0000, ackdt_q, 1'b0, arm_q};
		OFF_STATUS: rdata_d = {28'h0000000, full_q, write_collision_flag_q, ovf_q, irqf_q};
		OFF_MASK:   rdata_d = {29'h00000000, mask_q};
		default:    rdata_d = UNMAPPED_READ;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q  <= IMR_IDLE;
			brg_q    <= 16'h0000;
			reload_q <= BRG_RELOAD_RESET;
			cnt_q    <= 4'h0;
			shift_q  <= 8'h00;
			buf_q    <= 8'h00;
			scl_q    <= 1'b1;
			sda_q    <= 1'b1;
			arm_q    <= 1'b0;
			ackdt_q  <= 1'b0;
			mask_q   <= MASK_RESET;
			full_q   <= 1'b0;
			irqf_q   <= 1'b0;
			ovf_q    <= 1'b0;
			write_collision_flag_q   <= 1'b0;
			rd_ack_q <= 1'b0;
			rdata_q  <= 32'h00000000;
		end else begin
			state_q  <= state_d;
			brg_q    <= brg_d;
			reload_q <= reload_d;
			cnt_q    <= cnt_d;
			shift_q  <= shift_d;
			buf_q    <= buf_d;
			scl_q    <= scl_d;
			sda_q    <= sda_d;
			arm_q    <= arm_d;
			ackdt_q  <= ackdt_d;
			mask_q   <= mask_d;
			full_q   <= full_d;
			irqf_q   <= irqf_d;
			ovf_q    <= ovf_d;
			write_collision_flag_q   <= write_collision_flag_d;
			rd_ack_q <= rd_ack_d;
			rdata_q  <= rdata_d;
		end
	end

	// open drain: only ever drive low
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign pins.scl_oe = !scl_q;
	assign pins.sda_oe = !sda_q;
	assign avs_readdata = rdata_q;
	assign irq = |({write_collision_flag_q, ovf_q, irqf_q} & mask_q);

	a_arm_idle: assert property (@(posedge mclk) disable iff (!rst_n_q)
		state_q != IMR_IDLE && wr_ctrl |=> state_q != IMR_IDLE ||
		$past(byte_done)) else $error("arm accepted while busy");
	a_scl_toggle: assert property (@(posedge mclk) disable iff (!rst_n_q)
		state_q == IMR_RECV && rollover && !byte_done |=>
		scl_q != $past(scl_q)) else $error("scl did not toggle");
	a_byte_load: assert property (@(posedge mclk) disable iff (!rst_n_q)
		byte_done |=> !arm_q && full_q && irqf_q &&
		buf_q == $past(shift_q)) else $error("byte not loaded");
	a_hold_low: assert property (@(posedge mclk) disable iff (!rst_n_q)
		byte_done |=> (!scl_q && state_q == IMR_IDLE))
		else $error("scl not held low");
	a_read_clear: assert property (@(posedge mclk) disable iff (!rst_n_q)
		rd_buf && !byte_done |=> !full_q)
		else $error("full flag not cleared");
	a_overflow: assert property (@(posedge mclk) disable iff (!rst_n_q)
		byte_done && full_q && !rd_buf |=> ovf_q)
		else $error("overflow missed");
	a_write_collision_flag_set: assert property (@(posedge mclk) disable iff (!rst_n_q)
		wr_buf && state_q == IMR_RECV |=> write_collision_flag_q &&
		buf_q == $past(buf_q)) else $error("collision missed");
	a_ack_drive: assert property (@(posedge mclk) disable iff (!rst_n_q)
		state_q == IMR_ACK |-> sda_q == ackdt_q)
		else $error("ack level wrong");
	a_msb_first: assert property (@(posedge mclk) disable iff (!rst_n_q)
		state_q == IMR_RECV && rollover && !scl_q |=>
		shift_q[0] == $past(sda_s_q)) else $error("bad shift");
endmodule

// [tb/imr_slave_model.sv]
`timescale 1ns/10ps
module imr_slave_model (
	input  wire logic       scl,
	input  wire logic       go,
	input  wire logic [7:0] tx_byte,
	output logic            sda_oe
);
	logic [7:0] data_q = 8'hFF;
	logic [3:0] rises_q = 4'h8;
	logic [3:0] shown_q = 4'h8;
	always @(posedge scl or posedge go) begin
		if (go) begin
			data_q <= tx_byte;
			rises_q <= 4'h0;
		end else
			rises_q <= rises_q + 4'h1;
	end
	// next bit only appears while scl is low, so a high phase sees it stable
	always @(negedge scl or posedge go) begin
		if (go)
			shown_q <= 4'h0;
		else
			shown_q <= rises_q;
	end
	// released after the eighth bit: the pull-up lets the master ack
	assign sda_oe = (shown_q < 4'h8) ? ~data_q[3'h7 - shown_q[2:0]] : 1'b0;
endmodule

// [tb/imr_master_rx_tb.sv]
`timescale 1ns/10ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
	err_total++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module imr_master_rx_tb;
	import imr_pkg::*;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	imr_pins_s   pins;
	logic        irq;
	logic        slv_oe;
	logic        slv_go = 1'b0;
	logic [7:0]  slv_byte = 8'h00;
	logic        ack_seen = 1'b0;
	logic [31:0] rd;
	int          err_total = 0;
	int          num_checks = 0;
	int          cycles = 0;
	wire         scl_line = ~pins.scl_oe;
	wire         sda_line = ~(pins.sda_oe | slv_oe);
	imr_master_rx u_dut (.mclk(mclk), .reset_n(reset_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.scl_in(scl_line), .sda_in(sda_line), .pins(pins),
		.scl_out(), .sda_out(), .irq(irq));
	imr_slave_model u_slave (.scl(scl_line), .go(slv_go),
		.tx_byte(slv_byte), .sda_oe(slv_oe));
	always #2.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (pins.sda_oe === 1'b1)
			ack_seen <= 1'b1;
		if (cycles == 20000) begin
			err_total++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= 1'b1;
		// waitrequest is seen before this edge's updates land
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
		@(posedge mclk);
	endtask
	// optional mid-byte buffer write and re-arm, both must be dropped
	task automatic rx_byte(input logic [7:0] b, input logic clash);
		bus_wr(OFF_STATUS, 32'h1);
		slv_byte <= b;
		slv_go <= 1'b1;
		@(posedge mclk);
		slv_go <= 1'b0;
		bus_wr(OFF_CTRL, 32'h00020001);
		if (clash) begin
			bus_wr(OFF_BUF, 32'hFF);
			bus_wr(OFF_CTRL, 32'h00020001);
		end
		do bus_rd(OFF_STATUS, rd); while (rd[ST_IRQ_BIT] !== 1'b1);
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		repeat (4) @(posedge mclk);
		bus_rd(OFF_MASK, rd);
		`CHK("mask", 32'h0, rd)
		bus_rd(OFF_CTRL, rd);
		`CHK("ctrl", {BRG_RELOAD_RESET, 16'h0}, rd)
		bus_rd(4'h2, rd);
		`CHK("unmapped", UNMAPPED_READ, rd)
		$display("reset test done");
		rx_byte(8'hA5, 1'b0);
		`CHK("irq masked", 1'b0, irq)
		bus_rd(OFF_STATUS, rd);
		`CHK("status", 32'h9, rd)
		bus_rd(OFF_CTRL, rd);
		`CHK("arm cleared", 32'h00020000, rd)
		bus_wr(OFF_MASK, 32'h7);
		`CHK("irq", 1'b1, irq)
		repeat (20) @(posedge mclk);
		`CHK("scl held", 1'b1, pins.scl_oe)
		bus_rd(OFF_BUF, rd);
		`CHK("buffer", 8'hA5, rd[7:0])
		bus_rd(OFF_STATUS, rd);
		`CHK("full clear", 32'h1, rd)
		$display("receive test done");
		rx_byte(8'h5A, 1'b0);
		rx_byte(8'hC3, 1'b0);
		bus_rd(OFF_STATUS, rd);
		`CHK("overflow", 32'hB, rd)
		bus_rd(OFF_BUF, rd);
		bus_wr(OFF_STATUS, 32'h2);
		$display("overflow test done");
		rx_byte(8'h96, 1'b1);
		bus_rd(OFF_STATUS, rd);
		`CHK("collision", 32'hD, rd)
		bus_rd(OFF_CTRL, rd);
		`CHK("rearm dropped", 32'h00020000, rd)
		bus_rd(OFF_BUF, rd);
		`CHK("buffer kept", 8'h96, rd[7:0])
		bus_wr(OFF_STATUS, 32'h4);
		bus_rd(OFF_STATUS, rd);
		`CHK("write_collision_flag cleared", 32'h1, rd)
		$display("collision test done");
		bus_wr(OFF_STATUS, 32'h1);
		ack_seen = 1'b0;
		bus_wr(OFF_CTRL, 32'h00020002);
		do bus_rd(OFF_STATUS, rd); while (rd[ST_IRQ_BIT] !== 1'b1);
		`CHK("ack driven", 1'b1, ack_seen)
		$display("ack test done");
		report_and_stop();
	end
endmodule
